// *** verilog/pseq_map.svh ***
// Constants for the program sequencer: widths, depths, offsets, reset values.
// Assumes inclusion by bare name from the package and the sequencer core.
`ifndef PSEQ_MAP_SVH
`define PSEQ_MAP_SVH

// Address and stack geometry
`define PSEQ_AW 14
`define PSEQ_RS_DEPTH 16
`define PSEQ_RS_PW 5
`define PSEQ_CS_DEPTH 4
`define PSEQ_LS_DEPTH 4
`define PSEQ_SD_W 3
`define PSEQ_COND_W 4

// Termination condition code meaning counter expired
`define PSEQ_COND_CE 4'he

// Reset values
`define PSEQ_PC_RST 14'h0000
`define PSEQ_CNT_RST 14'h0000
`define PSEQ_CNT_ONE 14'h0001

// Avalon byte offsets
`define PSEQ_OFS_LOOP_COUNTER 8'h00
`define PSEQ_OFS_OWR 8'h04
`define PSEQ_OFS_TOP 8'h08
`define PSEQ_OFS_STAT 8'h0c
`define PSEQ_OFS_PC 8'h10

// Status register bit positions
`define PSEQ_ST_CS_EMPTY 0
`define PSEQ_ST_RS_EMPTY 1
`define PSEQ_ST_CNT_VALID 2
`define PSEQ_ST_LS_EMPTY 3
`define PSEQ_ST_RS_OVF 4

`endif

// *** verilog/pseq_pkg.sv ***
// Types shared by the program sequencer and its bench.
// Assumes pseq_map.svh is on the include path.
`include "pseq_map.svh"

package pseq_pkg;

    // Instruction class given by the decoder each cycle
    typedef enum logic [2:0] {
        PSEQ_K_SEQ = 3'b000,
        PSEQ_K_JUMP = 3'b001,
        PSEQ_K_CALL = 3'b010,
        PSEQ_K_RET = 3'b011,
        PSEQ_K_RTI = 3'b100,
        PSEQ_K_DO = 3'b101,
        PSEQ_K_IJUMP = 3'b110,
        PSEQ_K_IDLE = 3'b111
    } pseq_kind_t;

endpackage

// *** verilog/pseq_core.sv ***
// Program sequencer: next address select, program counter, return stack,
// loop counter with count stack, and loop stack.
// Assumes decoder, condition logic and interrupt inputs are on ref_clk,
// and an Avalon-MM master with byte addresses on the register port.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`include "pseq_map.svh"

// What this block does
// (RQ1) Pick prefetch source from decoder, conditions, interrupts
// (RQ2) Incremented address for sequential, untaken, loop exit
// (RQ3) Return stack top for returns and loop back
// (RQ4) Taken direct jump or call uses target field
// (RQ5) Recognised interrupt fetches its vector
// (RQ6) Indirect jump loads index register address
// (RQ7) 14-bit counter register with continuous incrementer
// (RQ8) Counter reloads from next-address mux every cycle
// (RQ9) 16-deep return stack pushed on call, loop setup
// (RQ10) Interrupt pushes unincremented address for refetch, incremented one if it interrupts an idle
// (RQ11) Explicit pop; pseudo-register reads pop, writes push
// (RQ12) 14-bit unsigned loop counter, post-decrement
// (RQ13) Counter load takes low 14 data bits, N
// (RQ14) Expired when counter equals one, decrement after
// (RQ15) Jump test decrements; return, arithmetic tests don't
// (RQ16) Counter readable unchanged, top bits zero
// (RQ17) 4-deep count stack pushed on counter load
// (RQ18) Expired test pops count stack; manual pop too
// (RQ19) No push while counter invalid
// (RQ20) Count stack empty shown in status register
// (RQ21) Overwrite port replaces counter, no push
// (RQ22) Loop setup pushes end and condition
// (RQ23) Reset empties stacks, invalidates counter
module pseq_core (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pseq_pkg::pseq_kind_t instr_kind,
    input wire logic instr_cond_true,
    input wire logic instr_tests_ce,
    input wire logic [13:0] instr_target,
    input wire logic [13:0] indirect_index_regs,
    input wire logic [13:0] loop_end_addr,
    input wire logic [3:0] loop_term_cond,
    input wire logic loop_cond_true,
    input wire logic irq_valid,
    input wire logic [13:0] irq_vector,
    input wire logic pop_return,
    input wire logic pop_count,
    input wire logic pop_loop,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [13:0] program_address_bus,
    output logic [13:0] loop_top_end,
    output logic [3:0] loop_top_cond,
    output logic [2:0] loop_depth
);

    // Index of the top return stack entry from the fill count
    function automatic logic [3:0] rs_top_idx(input logic [4:0] ptr);
        logic [4:0] t;
        t = ptr - 5'h01;
        return t[3:0];
    endfunction

    // Register select match for the bus port
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // Program counter and its incremented value
    logic [13:0] program_counter_reg; // Address of the executing instruction
    logic [13:0] pc_inc; // Always counter plus one
    logic [13:0] pc_next; // Output of the next-address mux

    // Return stack storage
    logic [13:0] rs_mem [0:`PSEQ_RS_DEPTH-1];
    logic [4:0] rs_ptr_reg; // Number of entries held
    logic rs_ovf_reg; // Sticky: a push was lost while full
    logic [13:0] rs_top; // Current top entry
    logic rs_empty;

    // Loop counter and count stack (shift stack, entry 0 on top)
    logic [13:0] loop_counter_reg;
    logic cnt_valid_reg; // Counter holds a usable count
    logic [13:0] cs_mem [0:`PSEQ_CS_DEPTH-1];
    logic [2:0] cs_depth_reg;
    logic ce; // Counter expired condition

    // Loop stack (shift stack, entry 0 on top)
    logic [13:0] ls_end [0:`PSEQ_LS_DEPTH-1];
    logic [3:0] ls_cond [0:`PSEQ_LS_DEPTH-1];
    logic [2:0] ls_depth_reg;
    logic loop_end; // Executing the last loop instruction

    // Sequencer stack and counter actions for this cycle
    logic explicit_xfer; // An explicit transfer overrides loop sequencing
    logic term; // Loop termination condition result
    logic seq_rs_push, seq_rs_pop, ls_push, ls_pop;
    logic [13:0] seq_rs_val;
    logic ce_tested, cnt_dec;

    // Bus handshake and decoded actions
    logic [31:0] readdata_reg, rd_mux;
    logic waitrequest_reg;
    logic req, blocked, go;
    logic bus_cnt_load, bus_owr, bus_rs_push, bus_rs_pop;
    logic rs_do_push, rs_do_pop;
    logic [13:0] rs_push_val;

    // Incrementer and stack/counter status terms
    always_comb begin
        pc_inc = program_counter_reg + `PSEQ_CNT_ONE; // RQ7
        rs_top = rs_mem[rs_top_idx(rs_ptr_reg)];
        rs_empty = rs_ptr_reg == 5'h00;
        // Expired is sampled from the counter at the start of the cycle
        ce = cnt_valid_reg && (loop_counter_reg == `PSEQ_CNT_ONE); // RQ14
        // Top loop is at its last instruction
        loop_end = (ls_depth_reg != 3'h0) && (program_counter_reg == ls_end[0]);
    end

    // Next address select; explicit transfers win over loop sequencing
    always_comb begin
        pc_next = pc_inc; // RQ2
        seq_rs_push = 1'b0;
        seq_rs_val = pc_inc;
        seq_rs_pop = 1'b0;
        ls_push = 1'b0;
        ls_pop = 1'b0;
        ce_tested = 1'b0;
        cnt_dec = 1'b0;
        explicit_xfer = 1'b0;
        term = 1'b0;
        if (irq_valid) begin
            // Vector fetch; current address saved so it is refetched
            pc_next = irq_vector; // RQ5
            seq_rs_push = 1'b1;
            // After an idle, resume past it rather than idling again
            seq_rs_val = (instr_kind == pseq_pkg::PSEQ_K_IDLE) ? pc_inc
                : program_counter_reg; // RQ10
            explicit_xfer = 1'b1;
        end else begin
            case (instr_kind) // RQ1
                pseq_pkg::PSEQ_K_JUMP: begin
                    // A jump testing expiry decrements, taken or not, unless an expired count pops, or with none stacked is marked invalid, instead
                    ce_tested = instr_tests_ce;
                    cnt_dec = instr_tests_ce; // RQ15
                    if (instr_cond_true) begin
                        pc_next = instr_target; // RQ4
                        explicit_xfer = 1'b1;
                    end
                end
                pseq_pkg::PSEQ_K_CALL: begin
                    if (instr_cond_true) begin
                        pc_next = instr_target; // RQ4
                        seq_rs_push = 1'b1; // RQ9
                        explicit_xfer = 1'b1;
                    end
                end
                pseq_pkg::PSEQ_K_RET: begin
                    // Return may test expiry but never decrements
                    ce_tested = instr_tests_ce; // RQ15
                    if (instr_cond_true) begin
                        pc_next = rs_top; // RQ3
                        seq_rs_pop = 1'b1;
                        explicit_xfer = 1'b1;
                    end
                end
                pseq_pkg::PSEQ_K_RTI: begin
                    pc_next = rs_top; // RQ3
                    seq_rs_pop = 1'b1;
                    explicit_xfer = 1'b1;
                end
                pseq_pkg::PSEQ_K_DO: begin
                    // First loop address and loop end pushed together
                    seq_rs_push = 1'b1; // RQ9
                    ls_push = 1'b1; // RQ22
                end
                pseq_pkg::PSEQ_K_IJUMP: begin
                    if (instr_cond_true) begin
                        pc_next = indirect_index_regs; // RQ6
                        explicit_xfer = 1'b1;
                    end
                end
                pseq_pkg::PSEQ_K_IDLE: begin
                    // Hold the fetch address until an interrupt arrives
                    pc_next = program_counter_reg;
                    explicit_xfer = 1'b1;
                end
                default: begin
                    // Conditional arithmetic may test expiry, no decrement
                    ce_tested = instr_tests_ce; // RQ15
                end
            endcase
        end
        // Implicit loop sequencing at the last loop instruction
        if (!explicit_xfer && loop_end) begin
            if (ls_cond[0] == `PSEQ_COND_CE) begin
                term = ce;
                ce_tested = 1'b1;
                cnt_dec = 1'b1;
            end else begin
                term = loop_cond_true;
            end
            if (term) begin
                // Fall out and drop this loop's stack entries
                pc_next = pc_inc; // RQ2
                ls_pop = 1'b1;
                seq_rs_pop = 1'b1;
            end else begin
                pc_next = rs_top; // RQ3
            end
        end
    end

    // Bus request qualification and decode
    always_comb begin
        req = avs_read || avs_write;
        // A bus stack or counter op waits while the sequencer uses it,
        // so the two never collide in one cycle
        blocked = (hit(avs_address, `PSEQ_OFS_TOP)
                && (seq_rs_push || seq_rs_pop || pop_return))
            || (avs_write && (hit(avs_address, `PSEQ_OFS_LOOP_COUNTER)
                || hit(avs_address, `PSEQ_OFS_OWR))
                && (ce_tested || pop_count));
        go = req && waitrequest_reg && !blocked;
        bus_cnt_load = go && avs_write && hit(avs_address, `PSEQ_OFS_LOOP_COUNTER);
        bus_owr = go && avs_write && hit(avs_address, `PSEQ_OFS_OWR);
        bus_rs_push = go && avs_write && hit(avs_address, `PSEQ_OFS_TOP);
        bus_rs_pop = go && avs_read && hit(avs_address, `PSEQ_OFS_TOP);
        rs_do_push = seq_rs_push || bus_rs_push;
        rs_do_pop = seq_rs_pop || pop_return || bus_rs_pop; // RQ11
        rs_push_val = bus_rs_push ? avs_writedata[13:0] : seq_rs_val;
    end

    // Read data mux; unmapped and write-only offsets read as zero
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            `PSEQ_OFS_LOOP_COUNTER: begin
                rd_mux = {18'h0, loop_counter_reg}; // RQ16
            end
            `PSEQ_OFS_TOP: begin
                rd_mux = {18'h0, rs_top}; // RQ11
            end
            `PSEQ_OFS_STAT: begin
                rd_mux[`PSEQ_ST_CS_EMPTY] = cs_depth_reg == 3'h0; // RQ20
                rd_mux[`PSEQ_ST_RS_EMPTY] = rs_empty;
                rd_mux[`PSEQ_ST_CNT_VALID] = cnt_valid_reg;
                rd_mux[`PSEQ_ST_LS_EMPTY] = ls_depth_reg == 3'h0;
                rd_mux[`PSEQ_ST_RS_OVF] = rs_ovf_reg;
            end
            `PSEQ_OFS_PC: begin
                rd_mux = {18'h0, program_counter_reg};
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    // The op acts on the edge that drops waitrequest; it rises
    // again at the master's completing edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h0;
        end else if (go) begin
            waitrequest_reg <= 1'b0;
            readdata_reg <= avs_read ? rd_mux : 32'h0;
        end else if (!waitrequest_reg) begin
            waitrequest_reg <= 1'b1;
        end
    end

    // Program counter reloads from the mux at every cycle end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            program_counter_reg <= `PSEQ_PC_RST;
        end else begin
            program_counter_reg <= pc_next; // RQ8
        end
    end

    // Return stack fill count and overflow flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rs_ptr_reg <= 5'h00; // RQ23
            rs_ovf_reg <= 1'b0;
        end else if (rs_do_push && !rs_do_pop) begin
            if (rs_ptr_reg == 5'(`PSEQ_RS_DEPTH)) begin
                // Full: the push is lost, software sees the flag
                rs_ovf_reg <= 1'b1;
            end else begin
                rs_ptr_reg <= rs_ptr_reg + 5'h01; // RQ9
            end
        end else if (rs_do_pop && !rs_do_push && !rs_empty) begin
            rs_ptr_reg <= rs_ptr_reg - 5'h01;
        end
    end

    // Return stack storage; push with pop in one cycle replaces the top
    always_ff @(posedge ref_clk) begin
        if (rs_do_push && rs_do_pop && !rs_empty) begin
            rs_mem[rs_top_idx(rs_ptr_reg)] <= rs_push_val;
        end else if (rs_do_push && !rs_do_pop
                && rs_ptr_reg != 5'(`PSEQ_RS_DEPTH)) begin
            rs_mem[rs_ptr_reg[3:0]] <= rs_push_val; // RQ10
        end
    end

    // Loop counter and count stack
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            loop_counter_reg <= `PSEQ_CNT_RST;
            cnt_valid_reg <= 1'b0; // RQ23
            cs_depth_reg <= 3'h0;
            for (int i = 0; i < `PSEQ_CS_DEPTH; i++) begin
                cs_mem[i] <= `PSEQ_CNT_RST;
            end
        end else if (bus_cnt_load) begin
            // Load takes N itself from the low data bits
            loop_counter_reg <= avs_writedata[13:0]; // RQ13
            cnt_valid_reg <= 1'b1;
            // An invalid count is not worth a stack slot
            if (cnt_valid_reg) begin // RQ19
                cs_mem[0] <= loop_counter_reg; // RQ17
                for (int i = 1; i < `PSEQ_CS_DEPTH; i++) begin
                    cs_mem[i] <= cs_mem[i-1];
                end
                if (cs_depth_reg != 3'(`PSEQ_CS_DEPTH)) begin
                    cs_depth_reg <= cs_depth_reg + 3'h1;
                end
            end
        end else if (bus_owr) begin
            loop_counter_reg <= avs_writedata[13:0]; // RQ21
            cnt_valid_reg <= 1'b1;
        end else if ((ce_tested && ce) || pop_count) begin
            // Restore the outer count, or on an expired test with none left mark invalid
            if (cs_depth_reg != 3'h0) begin
                loop_counter_reg <= cs_mem[0]; // RQ18
                for (int i = 0; i < `PSEQ_CS_DEPTH - 1; i++) begin
                    cs_mem[i] <= cs_mem[i+1];
                end
                cs_depth_reg <= cs_depth_reg - 3'h1;
            end else if (ce_tested && ce) begin
                cnt_valid_reg <= 1'b0; // RQ19
            end
        end else if (cnt_dec) begin
            loop_counter_reg <= loop_counter_reg - `PSEQ_CNT_ONE; // RQ12
        end
    end

    // Loop stack: end address and termination condition
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ls_depth_reg <= 3'h0;
            for (int i = 0; i < `PSEQ_LS_DEPTH; i++) begin
                ls_end[i] <= `PSEQ_PC_RST;
                ls_cond[i] <= 4'h0;
            end
        end else if (ls_push) begin
            ls_end[0] <= loop_end_addr; // RQ22
            ls_cond[0] <= loop_term_cond;
            for (int i = 1; i < `PSEQ_LS_DEPTH; i++) begin
                ls_end[i] <= ls_end[i-1];
                ls_cond[i] <= ls_cond[i-1];
            end
            if (ls_depth_reg != 3'(`PSEQ_LS_DEPTH)) begin
                ls_depth_reg <= ls_depth_reg + 3'h1;
            end
        end else if ((ls_pop || pop_loop) && ls_depth_reg != 3'h0) begin
            for (int i = 0; i < `PSEQ_LS_DEPTH - 1; i++) begin
                ls_end[i] <= ls_end[i+1];
                ls_cond[i] <= ls_cond[i+1];
            end
            ls_depth_reg <= ls_depth_reg - 3'h1;
        end
    end

    // Outputs come straight from flip-flops
    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign program_address_bus = program_counter_reg;
    assign loop_top_end = ls_end[0];
    assign loop_top_cond = ls_cond[0];
    assign loop_depth = ls_depth_reg;

endmodule // pseq_core

// *** verification/pseq_core_asserts.sv ***
// Port checker for the program sequencer core.
// Assumes it is bound onto pseq_core and sees only that module's ports.
module pseq_core_asserts (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pseq_pkg::pseq_kind_t instr_kind,
    input wire logic instr_cond_true,
    input wire logic [13:0] instr_target,
    input wire logic [13:0] indirect_index_regs,
    input wire logic [13:0] loop_end_addr,
    input wire logic irq_valid,
    input wire logic [13:0] irq_vector,
    input wire logic pop_return,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [13:0] program_address_bus,
    input wire logic [13:0] loop_top_end,
    input wire logic [2:0] loop_depth
);
    // Short aliases keep the properties readable
    logic [13:0] pab;
    pseq_pkg::pseq_kind_t k;
    // Taken branch without interrupt, no loop end here, no side traffic
    logic tk, no_lend, quiet;
    assign pab = program_address_bus;
    assign k = instr_kind;
    assign tk = instr_cond_true && !irq_valid;
    assign no_lend = (loop_depth == 3'h0) || (pab != loop_top_end);
    assign quiet = !pop_return && !avs_read && !avs_write && !irq_valid;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    property p_seq_inc;
        k == pseq_pkg::PSEQ_K_SEQ && !irq_valid && no_lend |=> pab == $past(pab) + 14'h1;
    endproperty
    a_seq_inc: assert property (p_seq_inc) else $error("sequential step wrong");
    property p_untaken;
        k == pseq_pkg::PSEQ_K_JUMP && !instr_cond_true && !irq_valid && no_lend
        |=> pab == $past(pab) + 14'h1;
    endproperty
    a_untaken: assert property (p_untaken) else $error("untaken jump moved");
    property p_jump;
        k == pseq_pkg::PSEQ_K_JUMP && tk |=> pab == $past(instr_target);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_irq;
        irq_valid |=> pab == $past(irq_vector);
    endproperty
    a_irq: assert property (p_irq) else $error("vector not fetched");
    property p_ijump;
        k == pseq_pkg::PSEQ_K_IJUMP && tk |=> pab == $past(indirect_index_regs);
    endproperty
    a_ijump: assert property (p_ijump) else $error("indirect jump wrong");
    // Call, one plain step, return: lands after the call
    property p_call_ret;
        k == pseq_pkg::PSEQ_K_CALL && tk ##1 k == pseq_pkg::PSEQ_K_SEQ && no_lend && quiet
        ##1 k == pseq_pkg::PSEQ_K_RET && instr_cond_true && quiet
        |=> pab == $past(pab, 3) + 14'h1;
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address wrong");
    property p_do;
        k == pseq_pkg::PSEQ_K_DO && !irq_valid && loop_depth < 3'h4
        |=> loop_top_end == $past(loop_end_addr) && loop_depth == $past(loop_depth) + 3'h1;
    endproperty
    a_do: assert property (p_do) else $error("loop push wrong");
    property p_rd_pad;
        !avs_waitrequest |-> avs_readdata[31:14] == 18'h0;
    endproperty
    a_rd_pad: assert property (p_rd_pad) else $error("read upper bits set");
    // One-cycle answer, else the master sees a second ack
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");

    c_call: cover property (k == pseq_pkg::PSEQ_K_CALL && tk);
    c_irq: cover property (irq_valid);
    c_do: cover property (k == pseq_pkg::PSEQ_K_DO);
endmodule // pseq_core_asserts

bind pseq_core pseq_core_asserts u_chk (
    .ref_clk, .resetn, .instr_kind, .instr_cond_true, .instr_target, .indirect_index_regs,
    .loop_end_addr, .irq_valid, .irq_vector, .pop_return, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .program_address_bus, .loop_top_end, .loop_depth
);

// *** verification/pseq_prog_model.sv ***
// Program memory and decoder model: decodes the word at the current address.
// Assumes the bench fills the arrays during reset; unfilled words are plain steps.
`include "pseq_map.svh"
module pseq_prog_model (
    input wire logic [13:0] program_address_bus,
    output pseq_pkg::pseq_kind_t instr_kind,
    output logic instr_cond_true,
    output logic [13:0] instr_target,
    output logic [13:0] loop_end_addr,
    output logic [3:0] loop_term_cond
);
    // Class, condition and address field per word; default is a plain step
    pseq_pkg::pseq_kind_t kind_mem [0:16383] = '{default: pseq_pkg::PSEQ_K_SEQ};
    logic cond_mem [0:16383] = '{default: 1'b1};
    logic [13:0] tgt_mem [0:16383] = '{default: 14'h0};

    // Decode is combinational: the executing word is whatever the bus shows
    assign instr_kind = kind_mem[program_address_bus];
    assign instr_cond_true = cond_mem[program_address_bus];
    assign instr_target = tgt_mem[program_address_bus];
    // Loop setup reuses the address field as the loop end
    assign loop_end_addr = tgt_mem[program_address_bus];
    // Only counted loops are issued, so the end test is always expiry
    assign loop_term_cond = `PSEQ_COND_CE;
endmodule // pseq_prog_model

// *** verification/pseq_core_tb.sv ***
// Self-checking bench for the program sequencer core.
// Assumes the model program below and the register map of pseq_map.svh.
`include "pseq_map.svh"
module pseq_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic irq_valid = 1'b0, pop_return = 1'b0, pop_count = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, instr_cond_true;
    logic [13:0] program_address_bus, instr_target, loop_end_addr, loop_top_end;
    logic [3:0] loop_term_cond, loop_top_cond;
    logic [2:0] loop_depth;
    pseq_pkg::pseq_kind_t instr_kind;
    int failures = 0;
    int checks = 0;
    // Expected fetch trace from the interrupt through the counted loop
    logic [13:0] tr [15] = '{14'h100, 14'h001, 14'h020, 14'h021, 14'h002, 14'h003,
        14'h040, 14'h041, 14'h042, 14'h041, 14'h042, 14'h041, 14'h042, 14'h043, 14'h050};

    always #25 ref_clk = ~ref_clk;

    pseq_core dut (.ref_clk, .resetn, .instr_kind, .instr_cond_true, .instr_tests_ce(1'b0),
        .instr_target, .indirect_index_regs(14'h040), .loop_end_addr, .loop_term_cond,
        .loop_cond_true(1'b0), .irq_valid, .irq_vector(14'h100), .pop_return, .pop_count,
        .pop_loop(1'b0), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .program_address_bus, .loop_top_end, .loop_top_cond, .loop_depth);

    pseq_prog_model mem (.program_address_bus, .instr_kind, .instr_cond_true, .instr_target,
        .loop_end_addr, .loop_term_cond);

    // Single comparison point for every result
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One Avalon transfer; held until waitrequest is seen low at an edge
    task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        av(1'b0, a, 32'h0);
        chk(q, exp, what);
    endtask

    task put(input logic [13:0] a, input pseq_pkg::pseq_kind_t k, input logic [13:0] t);
        mem.kind_mem[a] = k;
        mem.tgt_mem[a] = t;
    endtask

    // Reset state at the ports and in status
    task t_reset;
        @(posedge ref_clk);
        #1;
        chk({18'h0, program_address_bus}, 32'h0, "reset pc");
        rd(`PSEQ_OFS_STAT, 32'h0b, "reset status");
        $display("test reset done");
    endtask

    // First load skips the push, second pushes; high bus bits dropped
    task t_counter;
        av(1'b1, `PSEQ_OFS_LOOP_COUNTER, 32'h5);
        rd(`PSEQ_OFS_STAT, 32'h0f, "no push when invalid");
        av(1'b1, `PSEQ_OFS_LOOP_COUNTER, 32'hffffc003);
        rd(`PSEQ_OFS_LOOP_COUNTER, 32'h3, "counter load");
        rd(`PSEQ_OFS_LOOP_COUNTER, 32'h3, "counter reread");
        rd(`PSEQ_OFS_STAT, 32'h0e, "count pushed");
        $display("test counter done");
    endtask

    // Interrupt, call, return, jumps untaken, indirect and taken, loop of three
    task t_flow;
        @(posedge ref_clk) irq_valid <= 1'b1;
        foreach (tr[i]) begin
            @(posedge ref_clk) irq_valid <= 1'b0;
            #1;
            chk({18'h0, program_address_bus}, {18'h0, tr[i]}, "fetch");
        end
        rd(`PSEQ_OFS_LOOP_COUNTER, 32'h5, "outer count back");
        rd(`PSEQ_OFS_STAT, 32'h0f, "stacks empty");
        $display("test flow done");
    endtask

    // Overwrite without push, then load and manual count pop
    task t_overwrite;
        av(1'b1, `PSEQ_OFS_OWR, 32'h7);
        rd(`PSEQ_OFS_OWR, 32'h0, "overwrite unreadable");
        rd(`PSEQ_OFS_LOOP_COUNTER, 32'h7, "overwritten");
        rd(`PSEQ_OFS_STAT, 32'h0f, "no push on overwrite");
        av(1'b1, `PSEQ_OFS_LOOP_COUNTER, 32'h9);
        @(posedge ref_clk) pop_count <= 1'b1;
        @(posedge ref_clk) pop_count <= 1'b0;
        rd(`PSEQ_OFS_LOOP_COUNTER, 32'h7, "manual count pop");
        $display("test overwrite done");
    endtask

    // Stack pseudo-register push, manual pop, read pops
    task t_stack;
        av(1'b1, `PSEQ_OFS_TOP, 32'h55);
        av(1'b1, `PSEQ_OFS_TOP, 32'h123);
        rd(`PSEQ_OFS_STAT, 32'h0d, "stack pushed");
        @(posedge ref_clk) pop_return <= 1'b1;
        @(posedge ref_clk) pop_return <= 1'b0;
        rd(`PSEQ_OFS_TOP, 32'h55, "top after pop");
        rd(`PSEQ_OFS_STAT, 32'h0f, "stack emptied");
        rd(`PSEQ_OFS_PC, 32'h50, "pc read");
        rd(8'h1c, 32'h0, "unmapped");
        $display("test stack done");
    endtask

    task finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Program is loaded during reset; idles park the core for bus work
    initial begin
        repeat (2) @(posedge ref_clk);
        put(14'h000, pseq_pkg::PSEQ_K_IDLE, 14'h0);
        put(14'h100, pseq_pkg::PSEQ_K_RTI, 14'h0);
        put(14'h001, pseq_pkg::PSEQ_K_CALL, 14'h020);
        put(14'h021, pseq_pkg::PSEQ_K_RET, 14'h0);
        put(14'h002, pseq_pkg::PSEQ_K_JUMP, 14'h030);
        mem.cond_mem[2] = 1'b0;
        put(14'h003, pseq_pkg::PSEQ_K_IJUMP, 14'h0);
        put(14'h040, pseq_pkg::PSEQ_K_DO, 14'h042);
        put(14'h043, pseq_pkg::PSEQ_K_JUMP, 14'h050);
        put(14'h050, pseq_pkg::PSEQ_K_IDLE, 14'h0);
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_counter();
        t_flow();
        t_overwrite();
        t_stack();
        finish_test();
    end

    // About 100 cycles are needed; a hang is cut well beyond that
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        finish_test();
    end
endmodule // pseq_core_tb
